//--- logic/prig_map.svh
/*
  register map, field positions, reset values and timing counts of the remote
  contact input gating block. assumes a 32-bit apb slave with word offsets.
*/
`ifndef PRIG_MAP_SVH
`define PRIG_MAP_SVH

`define PRIG_OFF_CTRL      12'h000
`define PRIG_OFF_DELAY     12'h004
`define PRIG_OFF_CONTACTS  12'h008
`define PRIG_OFF_CMDS      12'h00C
`define PRIG_OFF_STATUS    12'h010
`define PRIG_OFF_MASK      12'h014

// ctrl fields
`define PRIG_CTRL_SRC_LSB   0
`define PRIG_CTRL_SRC_MSB   1
`define PRIG_CTRL_BOOST_EN  2
`define PRIG_CTRL_PURGE_EN  3
`define PRIG_CTRL_IDLE_EN   4
`define PRIG_CTRL_VALVE_LSB 5
`define PRIG_CTRL_VALVE_MSB 6
`define PRIG_CTRL_LATCH_EN  7
`define PRIG_CTRL_CODE_LSB  8
`define PRIG_CTRL_CODE_MSB  11
`define PRIG_CTRL_RST       32'h0000_0000

// control source, valve mode and purge codes
`define PRIG_SRC_REMOTE     2'h1
`define PRIG_VALVE_MANUAL   2'h1
`define PRIG_CODE_PURGE     4'h1

`define PRIG_DELAY_RST      16'h0000

// command outputs / status bits
`define PRIG_NCMD           6
`define PRIG_B_PUMP         0
`define PRIG_B_BOOST        1
`define PRIG_B_PURGE        2
`define PRIG_B_STBY         3
`define PRIG_B_VALVE        4
`define PRIG_B_CLEAR        5

// stand-by delay tick: 1 ms at 20 MHz
`define PRIG_TICK_NS        1000000
`define PRIG_CLK_NS         50
`define PRIG_TICK_CYC       (`PRIG_TICK_NS / `PRIG_CLK_NS)

`endif

//--- logic/prig_pkg.sv
/*
  types of the remote contact input gating block.
  assumes prig_map.svh for numeric values.
*/
package prig_pkg;
  typedef enum logic [1:0] {
    STBY_OFF,
    STBY_WAIT,
    STBY_ON
  } prig_stby_type;
endpackage

//--- logic/prig_debounce.sv
/*
  two flop synchroniser plus a stability counter for one contact input.
  assumes the input may bounce and is not related to pclk.
*/
`timescale 1ns/1ps
module prig_debounce #(
  parameter int CNT_W  = 16,
  parameter int STABLE = 20000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic raw,
  output logic      level
);
  logic             meta_r;
  logic             sync_r;
  logic [CNT_W-1:0] cnt_r;

  // first flop is read by the second only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end

  // level follows only after sync holds a new value for STABLE cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      level <= 1'b0;
    end else if (sync_r == level) begin
      cnt_r <= '0;
    end else if (cnt_r == CNT_W'(STABLE - 1)) begin
      cnt_r <= '0;
      level <= sync_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

//--- logic/prig_apb.sv
/*
  apb slave register file: control, delay, status w1c and mask.
  assumes a zero wait state apb master; unmapped reads return zero with pslverr.
*/
`timescale 1ns/1ps
`include "prig_map.svh"
module prig_apb
  import prig_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [7:0]            contacts,
  input  wire logic [`PRIG_NCMD-1:0] cmds,
  input  wire logic [`PRIG_NCMD-1:0] events,
  output logic      [31:0]           ctrl_r,
  output logic      [15:0]           delay_r,
  output logic                       irq
);
  logic [`PRIG_NCMD-1:0] status_r;
  logic [`PRIG_NCMD-1:0] mask_r;
  logic                  wr;
  logic                  rd;
  logic                  hit;

  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;

  // address decode used by the error answer only
  always_comb begin
    case (paddr)
      `PRIG_OFF_CTRL, `PRIG_OFF_DELAY, `PRIG_OFF_CONTACTS,
      `PRIG_OFF_CMDS, `PRIG_OFF_STATUS, `PRIG_OFF_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // writable configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= `PRIG_CTRL_RST;
      delay_r <= `PRIG_DELAY_RST;
      mask_r  <= '0;
    end else if (wr) begin
      if (paddr == `PRIG_OFF_CTRL) ctrl_r <= pwdata;
      if (paddr == `PRIG_OFF_DELAY) delay_r <= pwdata[15:0];
      if (paddr == `PRIG_OFF_MASK) mask_r <= pwdata[`PRIG_NCMD-1:0];
    end
  end

  // sticky status: a new event wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
    end else if (wr && paddr == `PRIG_OFF_STATUS) begin
      status_r <= (status_r & ~pwdata[`PRIG_NCMD-1:0]) | events;
    end else begin
      status_r <= status_r | events;
    end
  end

  // registered read data and answer, one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      irq     <= 1'b0;
    end else begin
      irq     <= |(status_r & mask_r);
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata  <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `PRIG_OFF_CTRL:     prdata <= ctrl_r;
          `PRIG_OFF_DELAY:    prdata <= {16'h0000, delay_r};
          `PRIG_OFF_CONTACTS: prdata <= {24'h000000, contacts};
          `PRIG_OFF_CMDS:     prdata <= {26'h0000000, cmds};
          `PRIG_OFF_STATUS:   prdata <= {26'h0000000, status_r};
          `PRIG_OFF_MASK:     prdata <= {26'h0000000, mask_r};
          default:            prdata <= '0;
        endcase
      end
    end
  end
endmodule

//--- logic/prig_top.sv
/*
  remote contact input gating of a vacuum pump controller: eight contact levels
  become pump, booster, purge, stand-by purge, inlet valve and warning-clear
  commands, gated by remote selection (except warning-clear) and configuration over apb.
  assumes contacts are high when closed; outputs drive the pump sequencer.
*/
`timescale 1ns/1ps
`include "prig_map.svh"

module prig_top
  import prig_pkg::*;
#(
  parameter int DB_CYC  = 20000,
  parameter int TICK    = `PRIG_TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        local_remote_sel_in,
  input  wire logic        pump_run_in,
  input  wire logic        booster_run_in,
  input  wire logic        purge_run_in,
  input  wire logic        standby_purge_in,
  input  wire logic        valve_close_in,
  input  wire logic        valve_close_permit_in,
  input  wire logic        warn_clear_in,
  input  wire logic        purge_fault_in,
  output logic             pump_run_r,
  output logic             booster_run_r,
  output logic             purge_run_r,
  output logic             standby_valve_closed_r,
  output logic             inlet_valve_close_r,
  output logic             valve_close_permit_r,
  output logic             purge_alarm_r,
  output logic             fault_clear_r,
  output logic             irq
);
  logic [7:0]            raw;
  logic [7:0]            db;
  logic [31:0]           ctrl;
  logic [15:0]           delay;
  logic                  src_remote;
  logic                  remote_ok;
  logic                  manual_valve_choice;
  logic                  clear_prev_r;
  logic [`PRIG_NCMD-1:0] cmds;
  logic [`PRIG_NCMD-1:0] cmds_prev_r;
  logic [`PRIG_NCMD-1:0] events;
  logic [31:0]           tick_r;
  logic [15:0]           wait_r;
  prig_stby_type         stby_r;

  assign raw = {warn_clear_in, valve_close_permit_in, valve_close_in, standby_purge_in,
                purge_run_in, booster_run_in, pump_run_in, local_remote_sel_in};

  // one filter per contact so bounce never reaches a command
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_db
      prig_debounce #(
        .CNT_W  (16),
        .STABLE (DB_CYC)
      ) u_db (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     (raw[gi]),
        .level   (db[gi])
      );
    end
  endgenerate

  // remote is validated by configuration and an open select contact
  assign src_remote = ctrl[`PRIG_CTRL_SRC_MSB:`PRIG_CTRL_SRC_LSB] == `PRIG_SRC_REMOTE;
  assign remote_ok  = src_remote & ~db[0];
  assign manual_valve_choice =
    ctrl[`PRIG_CTRL_VALVE_MSB:`PRIG_CTRL_VALVE_LSB] == `PRIG_VALVE_MANUAL;

  // pump, booster and purge follow their contacts while gated in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_run_r    <= 1'b0;
      booster_run_r <= 1'b0;
      purge_run_r   <= 1'b0;
    end else if (remote_ok) begin
      pump_run_r    <= db[1];
      if (ctrl[`PRIG_CTRL_BOOST_EN])
        booster_run_r <= db[2];
      if (ctrl[`PRIG_CTRL_PURGE_EN] &&
          ctrl[`PRIG_CTRL_CODE_MSB:`PRIG_CTRL_CODE_LSB] == `PRIG_CODE_PURGE)
        purge_run_r <= db[3];
    end
  end

  // millisecond tick for the stand-by delay; counts only while waiting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r <= '0;
    end else if (stby_r != STBY_WAIT || tick_r == 32'(TICK - 1)) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick_r + 32'h0000_0001;
    end
  end

  // stand-by purge: closed contact waits the programmed delay, open stops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stby_r <= STBY_OFF;
      wait_r <= '0;
      standby_valve_closed_r <= 1'b0;
    end else if (remote_ok && !ctrl[`PRIG_CTRL_IDLE_EN] && ctrl[`PRIG_CTRL_PURGE_EN]) begin
      case (stby_r)
        STBY_OFF: begin
          if (db[4]) begin
            stby_r <= STBY_WAIT;
            wait_r <= delay;
          end
        end
        STBY_WAIT: begin
          if (!db[4]) begin
            stby_r <= STBY_OFF;
          end else if (wait_r == 16'h0000) begin
            stby_r <= STBY_ON;
            standby_valve_closed_r <= 1'b1;
          end else if (tick_r == 32'(TICK - 1)) begin
            wait_r <= wait_r - 16'h0001;
          end
        end
        STBY_ON: begin
          if (!db[4]) begin
            stby_r <= STBY_OFF;
            standby_valve_closed_r <= 1'b0;
          end
        end
        default: stby_r <= STBY_OFF;
      endcase
    end
  end

  // permit needs the manual choice and the permit contact only; valve close needs remote, manual choice and permit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valve_close_permit_r <= 1'b0;
      inlet_valve_close_r  <= 1'b0;
    end else begin
      valve_close_permit_r <= manual_valve_choice & db[6];
      if (!(manual_valve_choice && db[6]))
        inlet_valve_close_r <= 1'b0;
      else if (remote_ok)
        inlet_valve_close_r <= db[5];
    end
  end

  // purge alarm is masked while the stand-by valve is closed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      purge_alarm_r <= 1'b0;
    end else begin
      purge_alarm_r <= purge_fault_in & ~standby_valve_closed_r;
    end
  end

  // rising edge of the clear contact gives a one-cycle clear pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_prev_r  <= 1'b0;
      fault_clear_r <= 1'b0;
    end else begin
      clear_prev_r  <= db[7];
      fault_clear_r <= ctrl[`PRIG_CTRL_LATCH_EN] & db[7] & ~clear_prev_r;
    end
  end

  assign cmds = {fault_clear_r, inlet_valve_close_r, standby_valve_closed_r,
                 purge_run_r, booster_run_r, pump_run_r};

  // any command change is an event for the sticky status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmds_prev_r <= '0;
    end else begin
      cmds_prev_r <= cmds;
    end
  end
  assign events = cmds ^ cmds_prev_r;

  prig_apb u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .contacts (db),
    .cmds     (cmds),
    .events   (events),
    .ctrl_r   (ctrl),
    .delay_r  (delay),
    .irq      (irq)
  );
endmodule

//--- dv/prig_asserts.sv
/*
  port checker of the remote contact gating block.
  assumes a single pclk domain; bound onto the top from the bench file.
*/
`timescale 1ns/1ps
module prig_asserts #(
  parameter int DB_CYC = 4,
  parameter int TICK   = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pump_run_in,
  input wire logic standby_purge_in,
  input wire logic warn_clear_in,
  input wire logic pump_run_r,
  input wire logic standby_valve_closed_r,
  input wire logic inlet_valve_close_r,
  input wire logic valve_close_permit_r,
  input wire logic purge_alarm_r,
  input wire logic fault_clear_r
);
  logic [1:0] raw_q;
  logic [7:0] pump_st;
  logic [7:0] stby_st;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since a contact last moved; saturates so a quiet contact never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_q   <= 2'h0;
      pump_st <= 8'h00;
      stby_st <= 8'h00;
    end else begin
      raw_q   <= {standby_purge_in, pump_run_in};
      pump_st <= (pump_run_in != raw_q[0]) ? 8'h00 : pump_st + {7'h0, pump_st != 8'hFF};
      stby_st <= (standby_purge_in != raw_q[1]) ? 8'h00 : stby_st + {7'h0, stby_st != 8'hFF};
    end
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  property p_apb_ready; s_setup ##1 s_access |-> pready; endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("access phase without ready");
  property p_ready_idle; !(psel && penable) |-> !pready; endproperty
  a_ready_idle: assert property (p_ready_idle)
    else $error("ready outside an access phase");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");
  property p_pump_follow; $changed(pump_run_r) |-> pump_run_r == pump_run_in && pump_st >= DB_CYC;
  endproperty
  a_pump_follow: assert property (p_pump_follow)
    else $error("pump command moved without a steady contact");
  property p_stby_rise; $rose(standby_valve_closed_r) |-> standby_purge_in && stby_st >= DB_CYC;
  endproperty
  a_stby_rise: assert property (p_stby_rise)
    else $error("stand-by valve closed without a steady contact");
  // permit and valve close update on the same edge, so a closed valve never lacks permit
  property p_valve_permit; !valve_close_permit_r |-> !inlet_valve_close_r;
  endproperty
  a_valve_permit: assert property (p_valve_permit)
    else $error("inlet valve kept closed without permit");
  property p_clear_pulse; fault_clear_r |-> warn_clear_in ##1 !fault_clear_r; endproperty
  a_clear_pulse: assert property (p_clear_pulse)
    else $error("fault clear not a single pulse on a closed contact");
  property p_alarm_quiet; standby_valve_closed_r [*2] |-> !purge_alarm_r; endproperty
  a_alarm_quiet: assert property (p_alarm_quiet)
    else $error("purge alarm while stand-by valve closed");
endmodule

//--- dv/prig_contacts.sv
/*
  customer contact bank: eight contacts and the purge fault line.
  assumes the bench sets the wanted levels; a moving contact may chatter.
*/
`timescale 1ns/1ps
module prig_contacts (
  input  wire logic       pclk,
  input  wire logic       chatter,
  input  wire logic [8:0] want,
  output logic      [8:0] lines
);
  logic [8:0] held   = 9'h000;
  logic [8:0] moved  = 9'h000;
  logic [1:0] bounce = 2'h0;
  int         seed   = 10;
  initial lines = 9'h000;
  // only the contacts that move bounce, for three cycles, so debounce is exercised
  always @(posedge pclk) begin
    held   <= want;
    moved  <= (want !== held) ? (want ^ held) : moved;
    bounce <= (want !== held && chatter) ? 2'h3 : (bounce != 2'h0) ? bounce - 2'h1 : 2'h0;
    lines  <= (bounce != 2'h0) ? ((held & ~moved) | (9'($random(seed)) & moved)) : held;
  end
endmodule

//--- dv/pump_remote_input_gating_test.sv
/*
  self-checking bench of the remote contact gating block.
  assumes the contact bank model and an apb slave without wait states.
*/
`timescale 1ns/1ps
`include "prig_map.svh"
module pump_remote_input_gating_test;
  localparam int DB = 4;
  localparam int TK = 3;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, chatter;
  logic        purge_alarm_r, fault_clear_r;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ctrl, r;
  logic [8:0]  want;
  logic [5:0]  cmd_exp;
  wire  [8:0]  lines;
  wire  [5:0]  outs;
  int          fails, n_compared, seed, n_clr, t0, t3;

  prig_top #(.DB_CYC(DB), .TICK(TK)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .local_remote_sel_in(lines[0]), .pump_run_in(lines[1]), .booster_run_in(lines[2]),
    .purge_run_in(lines[3]), .standby_purge_in(lines[4]), .valve_close_in(lines[5]),
    .valve_close_permit_in(lines[6]), .warn_clear_in(lines[7]), .purge_fault_in(lines[8]),
    .pump_run_r(outs[0]), .booster_run_r(outs[1]), .purge_run_r(outs[2]),
    .standby_valve_closed_r(outs[3]), .inlet_valve_close_r(outs[4]),
    .valve_close_permit_r(outs[5]), .purge_alarm_r(purge_alarm_r),
    .fault_clear_r(fault_clear_r), .irq(irq));
  prig_contacts i_bank (.pclk(pclk), .chatter(chatter), .want(want), .lines(lines));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // count clear pulses as seen at the edge, so each one-cycle pulse counts once
  always @(posedge pclk) begin
    if (fault_clear_r === 1'b1) n_clr <= n_clr + 1;
  end
  // hang guard, well beyond the few thousand cycles the run needs
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    report_and_stop();
  end

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; holds the request until ready is sampled, then idles one cycle
  // no wait limit here: only the hang guard ends a transfer that never answers
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // commands held while gating is false; valve close forced open without permit
  function automatic logic [5:0] exp_cmds(input logic [31:0] k, input logic [7:0] c,
                                         input logic [5:0] p);
    logic rem;
    logic man;
    rem = (k[1:0] == `PRIG_SRC_REMOTE) && !c[0];
    man = (k[6:5] == `PRIG_VALVE_MANUAL) && c[6];
    exp_cmds[0] = rem ? c[1] : p[0];
    exp_cmds[1] = (rem && k[2]) ? c[2] : p[1];
    exp_cmds[2] = (rem && k[3] && k[11:8] == `PRIG_CODE_PURGE) ? c[3] : p[2];
    exp_cmds[3] = (rem && k[3] && !k[4]) ? c[4] : p[3];
    exp_cmds[4] = !man ? 1'b0 : rem ? c[5] : p[4];
    exp_cmds[5] = man;
  endfunction
  // either the setting or the contacts change, then outputs, registers and clear count are compared; alarm only with fault or stand-by closed
  task automatic step(input logic [31:0] k, input logic [8:0] c);
    int n0;
    int ce;
    n0 = n_clr;
    ce = (k[7] && c[7] && !want[7]) ? 1 : 0;
    if (k !== ctrl) apb(1'b1, `PRIG_OFF_CTRL, k);
    ctrl = k;
    want <= c;
    repeat (30) @(posedge pclk);
    cmd_exp = exp_cmds(k, c[7:0], cmd_exp);
    check("outputs", {26'h0, outs}, {26'h0, cmd_exp});
    apb(1'b0, `PRIG_OFF_CMDS, 32'h0);
    check("cmd reg", rd & 32'h1F, {27'h0, cmd_exp[4:0]});
    apb(1'b0, `PRIG_OFF_CONTACTS, 32'h0);
    check("contacts", rd, {24'h0, c[7:0]});
    if (c[8] || cmd_exp[3]) check("alarm", {31'h0, purge_alarm_r}, {31'h0, c[8] && !cmd_exp[3]});
    check("clears", n_clr - n0, ce);
  endtask
  task automatic stby_time(output int t);
    t = 0;
    want <= 9'h010;
    do begin
      @(posedge pclk);
      t++;
    end while (outs[3] !== 1'b1 && t < 100);
    step(ctrl, 9'h000);
  endtask

  initial begin
    {psel, penable, pwrite, presetn, chatter} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    want = 9'h000;
    ctrl = 32'h0;
    cmd_exp = 6'h00;
    seed = 10;
    fails = 0;
    n_compared = 0;
    n_clr = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `PRIG_OFF_CTRL, 32'h0);
    check("ctrl rst", rd, `PRIG_CTRL_RST);
    apb(1'b0, `PRIG_OFF_DELAY, 32'h0);
    check("delay rst", rd, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    // pump change sets status; mask gates the interrupt; writing one clears it
    step(32'h1, 9'h000);
    apb(1'b1, `PRIG_OFF_STATUS, 32'h3F);
    step(32'h1, 9'h002);
    apb(1'b0, `PRIG_OFF_STATUS, 32'h0);
    check("status", rd, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, `PRIG_OFF_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    check("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, `PRIG_OFF_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    check("irq clr", {31'h0, irq}, 32'h0);
    // tick restarts on entering the wait, so three ticks of delay add three tick periods
    step(32'h9, 9'h000);
    stby_time(t0);
    apb(1'b1, `PRIG_OFF_DELAY, 32'h3);
    stby_time(t3);
    check("stby delay", {31'h0, t3 - t0 >= 2 * TK && t3 - t0 <= 3 * TK + 1}, 32'h1);
    chatter <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      apb(1'b1, `PRIG_OFF_DELAY, {30'h0, r[13:12]});
      step(ctrl, {r[21:14], want[0]});
      step(ctrl, {want[8:1], r[22] & r[23]});
      step({23'h0, r[8:0]}, want);
    end
    report_and_stop();
  end
endmodule

bind prig_top prig_asserts #(.DB_CYC(DB_CYC), .TICK(TICK)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .pump_run_in(pump_run_in), .standby_purge_in(standby_purge_in),
  .warn_clear_in(warn_clear_in), .pump_run_r(pump_run_r),
  .standby_valve_closed_r(standby_valve_closed_r), .inlet_valve_close_r(inlet_valve_close_r),
  .valve_close_permit_r(valve_close_permit_r), .purge_alarm_r(purge_alarm_r),
  .fault_clear_r(fault_clear_r));
